// ==== rtl/rsm_pkg.sv ====
package rsm_pkg;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_S = 1_000_000_000;
   localparam int UNIT_10MS_NS = 10_000_000;
   localparam int UNIT_100MS_NS = 100_000_000;
   localparam int UNIT_1S_NS = 1_000_000_000;
   localparam int UNIT_10MS_CYC = UNIT_10MS_NS / CLK_PERIOD_NS;
   localparam int UNIT_100MS_CYC = UNIT_100MS_NS / CLK_PERIOD_NS;
   localparam int UNIT_1S_CYC = UNIT_1S_NS / CLK_PERIOD_NS;

   // ***************************************************************
   // conversion and setting ranges
   // ***************************************************************
   localparam int SEC_PER_MIN = 60;
   localparam int SCALE_10MS = SEC_PER_MIN * (NS_PER_S / UNIT_10MS_NS);
   localparam int SCALE_100MS = SEC_PER_MIN * (NS_PER_S / UNIT_100MS_NS);
   localparam int SCALE_1S = SEC_PER_MIN * (NS_PER_S / UNIT_1S_NS);
   localparam int AVG_MIN = 1;
   localparam int AVG_MAX = 100;
   localparam int PPR_MIN = 1;
   localparam int PPR_MAX = 200000;

   // ***************************************************************
   // widths and status layout
   // ***************************************************************
   localparam int AVG_W = 7;
   localparam int PPR_W = 18;
   localparam int CNT_W = 24;
   localparam int SUM_W = CNT_W + AVG_W;
   localparam int SCALE_W = 13;
   localparam int NUM_W = SUM_W + SCALE_W;
   localparam int DEN_W = AVG_W + PPR_W;
   localparam int SPEED_W = 32;
   localparam int TICK_W = 27;
   localparam int BITC_W = 6;
   localparam int STATUS_W = 16;
   localparam int STAT_MEAS_BIT = 5;
   localparam int SYNC_N = 2;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {
      UT_10MS = 2'h0,
      UT_100MS = 2'h1,
      UT_1S = 2'h2
   } rsm_unit_t;

   typedef enum logic [2:0] {
      SRC_1P_X1_AONLY = 3'h0,
      SRC_1P_X2_AONLY = 3'h1,
      SRC_1P_X1 = 3'h2,
      SRC_1P_X2 = 3'h3,
      SRC_CW_CCW = 3'h4,
      SRC_2P_X1 = 3'h5,
      SRC_2P_X2 = 3'h6,
      SRC_2P_X4 = 3'h7
   } rsm_src_t;

   typedef struct packed {
      rsm_src_t src;
      rsm_unit_t unit;
      logic [AVG_W-1:0] depth;
      logic [PPR_W-1:0] ppr;
   } rsm_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN = 2'h1,
      ST_FETCH = 2'h2,
      ST_DIV = 2'h3
   } rsm_state_t;

endpackage

// ==== rtl/rsm_hist_mem.sv ====
`timescale 1ns/10ps
`default_nettype none

module rsm_hist_mem #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 100,
   parameter int AW = 7
) (
   // clock
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // read port, data one cycle later
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] rdata_d;

   always_comb begin
      rdata_d = rdata;
      if (re) begin
         rdata_d = mem[raddr];
      end
   end

   // array left unreset: stale words may be read while the window fills, but are discarded until rewritten
   always_ff @(posedge clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= rdata_d;
      end
   end

endmodule

`default_nettype wire

// ==== rtl/rsm_speed_meter.sv ====
// Function
// - Block acts only while rotation speed mode is selected.
// - Phase A/B pulses are counted and speed derived without further commands.
// - Averaging depth 1 to 100; depth 1 outputs each result directly.
// - Average of latest results; nothing output until depth results collected.
// - Unit time selectable 0.01 s, 0.1 s or 1 s; pulses counted per period.
// - Zero count in a unit time gives zero speed.
// - Down counting gives a negative signed speed.
// - Pulses per rotation 1 to 200000, used as divisor.
// - rpm equals 60 times count over unit time times pulses per rotation.
// - Fractional count carries forward so long-run sums track true rate.
// - Unaveraged granularity is 1, 10, 100 pulse/s for 1, 0.1, 0.01 s.
// - Multiplied modes compute speed from the multiplied edge count.
// - Phase Z, function, latch inputs and coincidence outputs are left unused.
// - Command on starts measuring and sets the in-measurement flag to 1.
// - Command off stops, clears the flag and forces speed to zero.
`timescale 1ns/10ps
`default_nettype none

module rsm_speed_meter #(
   parameter int UNIT_10MS_CYC = rsm_pkg::UNIT_10MS_CYC,
   parameter int UNIT_100MS_CYC = rsm_pkg::UNIT_100MS_CYC,
   parameter int UNIT_1S_CYC = rsm_pkg::UNIT_1S_CYC,
   parameter int AVG_MAX = rsm_pkg::AVG_MAX,
   parameter int PPR_MAX = rsm_pkg::PPR_MAX
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic CE,
   // encoder pins
   input wire logic PHASE_A,
   input wire logic PHASE_B,
   // control from the controller program
   input wire logic SPEED_MODE_SELECTED,
   input wire logic SPEED_MEASURE_COMMAND,
   input wire rsm_pkg::rsm_cfg_t CFG,
   // results
   output logic signed [rsm_pkg::SPEED_W-1:0] SPEED_VALUE,
   output logic SPEED_VALID,
   output logic SPEED_MEASURING_FLAG,
   output logic [rsm_pkg::STATUS_W-1:0] CHANNEL_STATUS_WORD
);

   localparam int AW = rsm_pkg::AVG_W;
   localparam int CW = rsm_pkg::CNT_W;
   localparam int SW = rsm_pkg::SUM_W;
   localparam int NW = rsm_pkg::NUM_W;
   localparam int DW = rsm_pkg::DEN_W;
   localparam int QW = rsm_pkg::SPEED_W;
   localparam int TW = rsm_pkg::TICK_W;
   localparam logic [NW-1:0] SPEED_POS_MAX = {{(NW-QW+1){1'b0}}, {(QW-1){1'b1}}};

   // ***************************************************************
   // decoding functions
   // ***************************************************************
   function automatic logic [TW-1:0] period_last(input rsm_pkg::rsm_unit_t u);
      case (u)
         rsm_pkg::UT_10MS: period_last = TW'(UNIT_10MS_CYC - 1);
         rsm_pkg::UT_100MS: period_last = TW'(UNIT_100MS_CYC - 1);
         default: period_last = TW'(UNIT_1S_CYC - 1);
      endcase
   endfunction

   // 60 / unit time, so rpm = count * scale / (depth * ppr)
   function automatic logic [rsm_pkg::SCALE_W-1:0] rpm_scale(input rsm_pkg::rsm_unit_t u);
      case (u)
         rsm_pkg::UT_10MS: rpm_scale = rsm_pkg::SCALE_W'(rsm_pkg::SCALE_10MS);
         rsm_pkg::UT_100MS: rpm_scale = rsm_pkg::SCALE_W'(rsm_pkg::SCALE_100MS);
         default: rpm_scale = rsm_pkg::SCALE_W'(rsm_pkg::SCALE_1S);
      endcase
   endfunction

   function automatic rsm_pkg::rsm_cfg_t clamp_cfg(input rsm_pkg::rsm_cfg_t c);
      clamp_cfg = c;
      if (c.depth < AW'(rsm_pkg::AVG_MIN)) begin
         clamp_cfg.depth = AW'(rsm_pkg::AVG_MIN);
      end else if (c.depth > AW'(AVG_MAX)) begin
         clamp_cfg.depth = AW'(AVG_MAX);
      end
      if (c.ppr < rsm_pkg::PPR_W'(rsm_pkg::PPR_MIN)) begin
         clamp_cfg.ppr = rsm_pkg::PPR_W'(rsm_pkg::PPR_MIN);
      end else if (c.ppr > rsm_pkg::PPR_W'(PPR_MAX)) begin
         clamp_cfg.ppr = rsm_pkg::PPR_W'(PPR_MAX);
      end
      if (c.unit != rsm_pkg::UT_10MS && c.unit != rsm_pkg::UT_100MS) begin
         clamp_cfg.unit = rsm_pkg::UT_1S;
      end
   endfunction

   // signed step for one cycle; each multiplied edge counts once
   function automatic logic signed [1:0] edge_step(input rsm_pkg::rsm_src_t s, input logic a0, input logic b0,
                                                   input logic a1, input logic b1);
      logic a_r;
      logic a_f;
      logic b_r;
      logic b_e;
      a_r = a1 & ~a0;
      a_f = a0 & ~a1;
      b_r = b1 & ~b0;
      b_e = b1 ^ b0;
      edge_step = 2'sh0;
      case (s)
         rsm_pkg::SRC_1P_X1_AONLY: edge_step = a_r ? 2'sh1 : 2'sh0;
         rsm_pkg::SRC_1P_X2_AONLY: edge_step = (a_r | a_f) ? 2'sh1 : 2'sh0;
         rsm_pkg::SRC_1P_X1: edge_step = a_r ? (b1 ? -2'sh1 : 2'sh1) : 2'sh0;
         rsm_pkg::SRC_1P_X2: edge_step = (a_r | a_f) ? (b1 ? -2'sh1 : 2'sh1) : 2'sh0;
         rsm_pkg::SRC_CW_CCW: edge_step = (a_r && !b_r) ? 2'sh1 : ((b_r && !a_r) ? -2'sh1 : 2'sh0);
         rsm_pkg::SRC_2P_X1: edge_step = !b1 ? (a_r ? 2'sh1 : (a_f ? -2'sh1 : 2'sh0)) : 2'sh0;
         rsm_pkg::SRC_2P_X2: edge_step = (a_r | a_f) ? ((a1 != b1) ? 2'sh1 : -2'sh1) : 2'sh0;
         rsm_pkg::SRC_2P_X4: begin
            if (a_r | a_f) begin
               edge_step = (a1 != b1) ? 2'sh1 : -2'sh1;
            end else if (b_e) begin
               edge_step = (a1 == b1) ? 2'sh1 : -2'sh1;
            end
         end
         default: edge_step = 2'sh0;
      endcase
   endfunction

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   logic [rsm_pkg::SYNC_N-1:0] pin_in;
   logic [rsm_pkg::SYNC_N-1:0] s1_q, s2_q, s3_q, flt_q;
   logic [rsm_pkg::SYNC_N-1:0] s1_d, s2_d, s3_d, flt_d;

   assign pin_in = {PHASE_B, PHASE_A};

   // a level counts once the second and third stages agree
   genvar g;
   generate
      for (g = 0; g < rsm_pkg::SYNC_N; g++) begin : g_sync
         always_comb begin
            s1_d[g] = pin_in[g];
            s2_d[g] = s1_q[g];
            s3_d[g] = s2_q[g];
            flt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : flt_q[g];
         end
      end
   endgenerate

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         flt_q <= '0;
      end else if (CE) begin
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         flt_q <= flt_d;
      end
   end

   // ***************************************************************
   // measurement state
   // ***************************************************************
   rsm_pkg::rsm_state_t state_q, state_d;
   rsm_pkg::rsm_cfg_t cfg_q, cfg_d;
   logic [TW-1:0] tick_q, tick_d;
   logic signed [CW-1:0] ucnt_q, ucnt_d;
   logic signed [CW-1:0] sample_q, sample_d;
   logic signed [SW-1:0] sum_q, sum_d;
   logic [AW-1:0] wptr_q, wptr_d;
   logic [AW-1:0] fill_q, fill_d;
   logic [DW:0] rem_q, rem_d;
   logic [NW-1:0] quo_q, quo_d;
   logic [DW-1:0] den_q, den_d;
   logic neg_q, neg_d;
   logic [rsm_pkg::BITC_W-1:0] bitc_q, bitc_d;
   logic signed [QW-1:0] speed_q, speed_d;
   logic valid_q, valid_d;
   logic flag_q, flag_d;
   logic [rsm_pkg::STATUS_W-1:0] status_q, status_d;

   logic run;
   logic boundary;
   logic signed [1:0] step;
   logic signed [CW-1:0] mem_rdata;
   logic [CW-1:0] mem_rdata_raw;
   logic mem_we;
   logic mem_re;
   logic signed [SW-1:0] oldest;
   logic signed [SW-1:0] sum_new;
   logic [SW-1:0] mag;
   logic [DW:0] trial;
   logic [NW-1:0] qsat;

   // phase z, function, latch and coincidence pins stay outside this block
   assign run = SPEED_MEASURE_COMMAND & SPEED_MODE_SELECTED;
   assign step = edge_step(cfg_q.src, flt_q[0], flt_q[1], flt_d[0], flt_d[1]);
   assign boundary = (tick_q == period_last(cfg_q.unit));
   assign mem_rdata = $signed(mem_rdata_raw);

   always_comb begin
      state_d = state_q;
      cfg_d = cfg_q;
      tick_d = tick_q;
      ucnt_d = ucnt_q;
      sample_d = sample_q;
      sum_d = sum_q;
      wptr_d = wptr_q;
      fill_d = fill_q;
      rem_d = rem_q;
      quo_d = quo_q;
      den_d = den_q;
      neg_d = neg_q;
      bitc_d = bitc_q;
      speed_d = speed_q;
      valid_d = 1'b0;
      flag_d = flag_q;
      mem_we = 1'b0;
      mem_re = 1'b0;
      oldest = '0;
      sum_new = sum_q;
      mag = '0;
      trial = '0;
      qsat = '0;

      if (state_q != rsm_pkg::ST_IDLE) begin
         tick_d = boundary ? '0 : tick_q + TW'(1);
         // counter is sampled, never rescaled: the partial pulse rolls into the next period
         ucnt_d = boundary ? CW'(step) : ucnt_q + CW'(step);
      end

      case (state_q)
         rsm_pkg::ST_IDLE: begin
            speed_d = '0;
            flag_d = 1'b0;
            if (run) begin
               cfg_d = clamp_cfg(CFG);
               tick_d = '0;
               // start edge opens the first period, so every period spans the same number of clock cycles
               ucnt_d = CW'(step);
               sum_d = '0;
               wptr_d = '0;
               fill_d = '0;
               flag_d = 1'b1;
               state_d = rsm_pkg::ST_RUN;
            end
         end
         rsm_pkg::ST_RUN: begin
            if (boundary) begin
               sample_d = ucnt_q;
               mem_re = 1'b1;
               state_d = rsm_pkg::ST_FETCH;
            end
         end
         rsm_pkg::ST_FETCH: begin
            // oldest word only leaves the window once it is full
            oldest = (fill_q == cfg_q.depth) ? SW'(mem_rdata) : '0;
            sum_new = sum_q + SW'(sample_q) - oldest;
            sum_d = sum_new;
            mem_we = 1'b1;
            wptr_d = (wptr_q == cfg_q.depth - AW'(1)) ? '0 : wptr_q + AW'(1);
            fill_d = (fill_q == cfg_q.depth) ? fill_q : fill_q + AW'(1);
            if (fill_d == cfg_q.depth) begin
               mag = sum_new[SW-1] ? SW'(-sum_new) : SW'(sum_new);
               neg_d = sum_new[SW-1];
               quo_d = NW'(mag) * NW'(rpm_scale(cfg_q.unit));
               den_d = DW'(cfg_q.depth) * DW'(cfg_q.ppr);
               rem_d = '0;
               bitc_d = '0;
               state_d = rsm_pkg::ST_DIV;
            end else begin
               state_d = rsm_pkg::ST_RUN;
            end
         end
         rsm_pkg::ST_DIV: begin
            // one quotient bit per cycle keeps the divider small
            trial = {rem_q[DW-1:0], quo_q[NW-1]};
            if (trial >= {1'b0, den_q}) begin
               rem_d = trial - {1'b0, den_q};
               quo_d = {quo_q[NW-2:0], 1'b1};
            end else begin
               rem_d = trial;
               quo_d = {quo_q[NW-2:0], 1'b0};
            end
            bitc_d = bitc_q + rsm_pkg::BITC_W'(1);
            if (bitc_q == rsm_pkg::BITC_W'(NW - 1)) begin
               qsat = (quo_d > SPEED_POS_MAX) ? SPEED_POS_MAX : quo_d;
               // zero count divides to zero
               speed_d = neg_q ? -QW'(qsat) : QW'(qsat);
               valid_d = 1'b1;
               state_d = rsm_pkg::ST_RUN;
            end
         end
         default: begin
            state_d = rsm_pkg::ST_IDLE;
         end
      endcase

      // a held command is not restarted; only a drop of command or mode select ends the run
      if (!run && state_q != rsm_pkg::ST_IDLE) begin
         state_d = rsm_pkg::ST_IDLE;
         speed_d = '0;
         flag_d = 1'b0;
         valid_d = 1'b0;
      end

      status_d = '0;
      status_d[rsm_pkg::STAT_MEAS_BIT] = flag_d;
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         state_q <= rsm_pkg::ST_IDLE;
         cfg_q <= '0;
         tick_q <= '0;
         ucnt_q <= '0;
         sample_q <= '0;
         sum_q <= '0;
         wptr_q <= '0;
         fill_q <= '0;
         rem_q <= '0;
         quo_q <= '0;
         den_q <= '0;
         neg_q <= 1'b0;
         bitc_q <= '0;
         speed_q <= '0;
         valid_q <= 1'b0;
         flag_q <= 1'b0;
         status_q <= '0;
      end else if (CE) begin
         state_q <= state_d;
         cfg_q <= cfg_d;
         tick_q <= tick_d;
         ucnt_q <= ucnt_d;
         sample_q <= sample_d;
         sum_q <= sum_d;
         wptr_q <= wptr_d;
         fill_q <= fill_d;
         rem_q <= rem_d;
         quo_q <= quo_d;
         den_q <= den_d;
         neg_q <= neg_d;
         bitc_q <= bitc_d;
         speed_q <= speed_d;
         valid_q <= valid_d;
         flag_q <= flag_d;
         status_q <= status_d;
      end
   end

   // ***************************************************************
   // history of unit-time counts
   // ***************************************************************
   rsm_hist_mem #(
      .WIDTH(CW),
      .DEPTH(AVG_MAX),
      .AW(AW)
   ) u_hist (
      .clk(CLOCK),
      .nrst(NRST),
      .ce(CE),
      .we(mem_we),
      .waddr(wptr_q),
      .wdata(sample_q),
      .re(mem_re),
      .raddr(wptr_q),
      .rdata(mem_rdata_raw)
   );

   assign SPEED_VALUE = speed_q;
   assign SPEED_VALID = valid_q;
   assign SPEED_MEASURING_FLAG = flag_q;
   assign CHANNEL_STATUS_WORD = status_q;

endmodule

`default_nettype wire

// ==== sim/rsm_encoder_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// ***************************************************************
// quadrature encoder turning at a fixed rate
// ***************************************************************
module rsm_encoder_model (
   // clock
   input wire logic clk,
   input wire logic nrst,
   // motion
   input wire logic run,
   input wire logic rev,
   input wire logic cw_mode,
   input wire logic dir_mode,
   input wire logic signed [31:0] tper,
   // encoder pins
   output logic pha,
   output logic phb
);
   int ph_q;
   int ph_d;
   logic x;
   logic y;

   // stopped shaft holds its last levels
   always_comb begin
      ph_d = ph_q;
      if (run) begin
         ph_d = (ph_q + 1 >= tper) ? 0 : ph_q + 1;
      end
      x = ph_q < tper / 2;
      // b lags a by a quarter turn while going forward
      y = (tper > 0) && (((ph_q + tper - tper / 4) % tper) < tper / 2);
      // one-phase direction modes (codes 2 and 3) read b as a steady direction level, not a second phase
      pha = cw_mode ? (!rev && x) : (dir_mode ? x : (rev ? y : x));
      phb = cw_mode ? (rev && x) : (dir_mode ? rev : (rev ? x : y));
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ph_q <= 0;
      end else begin
         ph_q <= ph_d;
      end
   end
endmodule

`default_nettype wire

// ==== sim/rsm_checker.sv ====
`timescale 1ns/10ps
`default_nettype none

module rsm_checker #(
   parameter int UNIT_10MS_CYC = 100,
   parameter int UNIT_100MS_CYC = 200,
   parameter int UNIT_1S_CYC = 400
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic NRST,
   input wire logic CE,
   // inputs
   input wire logic PHASE_A,
   input wire logic PHASE_B,
   input wire logic SPEED_MODE_SELECTED,
   input wire logic SPEED_MEASURE_COMMAND,
   input wire rsm_pkg::rsm_cfg_t CFG,
   // outputs
   input wire logic signed [rsm_pkg::SPEED_W-1:0] SPEED_VALUE,
   input wire logic SPEED_VALID,
   input wire logic SPEED_MEASURING_FLAG,
   input wire logic [rsm_pkg::STATUS_W-1:0] CHANNEL_STATUS_WORD
);
   int since_q;
   int since_d;
   int gap_q;
   int gap_d;
   int per;
   logic seen_q;
   logic seen_d;

   // ***************************************************************
   // result spacing helpers
   // ***************************************************************
   always_comb begin
      per = (CFG.unit == rsm_pkg::UT_10MS) ? UNIT_10MS_CYC :
            (CFG.unit == rsm_pkg::UT_100MS) ? UNIT_100MS_CYC : UNIT_1S_CYC;
      since_d = SPEED_MEASURING_FLAG ? since_q + 1 : 0;
      gap_d = SPEED_VALID ? 1 : gap_q + 1;
      seen_d = SPEED_MEASURING_FLAG && (seen_q || SPEED_VALID);
   end

   always_ff @(posedge CLOCK or negedge NRST) begin
      if (!NRST) begin
         since_q <= 0;
         gap_q <= 0;
         seen_q <= 1'b0;
      end else begin
         since_q <= since_d;
         gap_q <= gap_d;
         seen_q <= seen_d;
      end
   end

   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!NRST);

   property p_start;
      !SPEED_MEASURING_FLAG && SPEED_MEASURE_COMMAND && SPEED_MODE_SELECTED && $past(NRST) |=> SPEED_MEASURING_FLAG;
   endproperty
   a_start: assert property (p_start) else $error("flag did not rise on start");

   property p_stop;
      SPEED_MEASURING_FLAG && !(SPEED_MEASURE_COMMAND && SPEED_MODE_SELECTED) |=>
         !SPEED_MEASURING_FLAG && SPEED_VALUE == 0;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not clear flag and speed");

   property p_status;
      CHANNEL_STATUS_WORD == {10'h000, SPEED_MEASURING_FLAG, 5'h00};
   endproperty
   a_status: assert property (p_status) else $error("status word differs from flag");

   property p_idle;
      !SPEED_MEASURING_FLAG |-> SPEED_VALUE == 0 && !SPEED_VALID;
   endproperty
   a_idle: assert property (p_idle) else $error("speed not zero while stopped");

   property p_mode;
      !SPEED_MODE_SELECTED && !SPEED_MEASURING_FLAG |=> !SPEED_MEASURING_FLAG;
   endproperty
   a_mode: assert property (p_mode) else $error("started with mode off");

   property p_hold;
      SPEED_MEASURING_FLAG && $past(SPEED_MEASURING_FLAG) && !SPEED_VALID |-> $stable(SPEED_VALUE);
   endproperty
   a_hold: assert property (p_hold) else $error("speed changed without a result");

   property p_period;
      SPEED_VALID && seen_q |-> gap_q == per;
   endproperty
   a_period: assert property (p_period) else $error("result spacing is not one unit time");

   property p_fill;
      SPEED_VALID && !seen_q |-> since_q >= CFG.depth * per && since_q <= CFG.depth * per + 60;
   endproperty
   a_fill: assert property (p_fill) else $error("first result before history filled");
endmodule

`default_nettype wire

// ==== sim/rotation_speed_meter_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module rotation_speed_meter_tb_top;
   // short unit times keep the run brief
   localparam int P10 = 100;
   localparam int P100 = 200;
   localparam int P1 = 400;
   logic clk;
   logic nrst;
   logic mode;
   logic cmd;
   logic run;
   logic rev;
   logic cwm;
   logic dm;
   logic ea;
   logic eb;
   logic vld;
   logic flag;
   int tper;
   int failures;
   int samples_checked;
   rsm_pkg::rsm_cfg_t cfg;
   logic signed [rsm_pkg::SPEED_W-1:0] spd;
   logic [rsm_pkg::STATUS_W-1:0] stat;
   logic [31:0] rng;
   logic [31:0] expq[$];

   rsm_speed_meter #(.UNIT_10MS_CYC(P10), .UNIT_100MS_CYC(P100), .UNIT_1S_CYC(P1)) uut (
      .CLOCK(clk), .NRST(nrst), .CE(1'b1), .PHASE_A(ea), .PHASE_B(eb),
      .SPEED_MODE_SELECTED(mode), .SPEED_MEASURE_COMMAND(cmd), .CFG(cfg),
      .SPEED_VALUE(spd), .SPEED_VALID(vld), .SPEED_MEASURING_FLAG(flag), .CHANNEL_STATUS_WORD(stat)
   );

   rsm_encoder_model enc (
      .clk(clk), .nrst(nrst), .run(run), .rev(rev), .cw_mode(cwm), .dir_mode(dm), .tper(tper), .pha(ea),
      .phb(eb)
   );

   // ***************************************************************
   // helpers
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // one run: sum is the signed count over depth unit times
   task automatic measure(input int s, input int u, input int d, input int ppr, input int tp,
         input logic rv, input longint sum, input int n);
      longint v;
      int k;
      cfg.src = rsm_pkg::rsm_src_t'(s[2:0]);
      cfg.unit = rsm_pkg::rsm_unit_t'(u[1:0]);
      cfg.depth = d[6:0];
      cfg.ppr = ppr[17:0];
      tper = tp;
      rev = rv;
      cwm = (s == 4);
      dm = (s == 2 || s == 3);
      run = (tp != 0);
      // flag has read stopped long before the next start
      step(50);
      v = sum * (u == 0 ? rsm_pkg::SCALE_10MS : u == 1 ? rsm_pkg::SCALE_100MS : rsm_pkg::SCALE_1S) / (d * ppr);
      for (k = 0; k < n; k++) begin
         expq.push_back(v[31:0]);
      end
      cmd = 1'b1;
      step(1);
      check("flag on", 32'h1, {31'h0, flag});
      check("status on", 32'h20, {16'h0, stat});
      k = 0;
      while (expq.size() != 0 && k < 20000) begin
         step(1);
         k++;
      end
      cmd = 1'b0;
      step(1);
      check("speed off", 32'h0, spd);
      check("flag off", 32'h0, {31'h0, flag});
      check("pending results", 32'h0, expq.size());
      expq.delete();
   endtask

   // ***************************************************************
   // result monitor
   // ***************************************************************
   always @(posedge clk) begin
      if (vld === 1'b1) begin
         if (expq.size() == 0) begin
            check("unexpected result", 32'h0, 32'h1);
         end else begin
            check("speed", expq.pop_front(), spd);
         end
      end
   end

   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      int m;
      nrst = 1'b0;
      mode = 1'b0;
      cmd = 1'b0;
      run = 1'b0;
      rev = 1'b0;
      cwm = 1'b0;
      dm = 1'b0;
      tper = 20;
      cfg = '0;
      failures = 0;
      samples_checked = 0;
      rng = 32'h00007672;
      step(5);
      nrst = 1'b1;
      cmd = 1'b1;
      step(3);
      check("flag with mode off", 32'h0, {31'h0, flag});
      cmd = 1'b0;
      mode = 1'b1;
      for (int s = 0; s < 8; s++) begin
         for (int r = 0; r < 2; r++) begin
            rng = xs(rng);
            m = (s == 1 || s == 3 || s == 6) ? 2 : (s == 7 ? 4 : 1);
            measure(s, 0, 1, int'(rng % 200) + 1, 20, r[0], (r == 1 && s > 1 ? -5 : 5) * m, 2);
         end
      end
      measure(7, 1, 1, 60, 20, 1'b0, 40, 2);
      measure(7, 2, 1, 60, 20, 1'b0, 80, 2);
      // unit code 3 falls back to the 1 s period
      measure(7, 3, 1, 60, 20, 1'b0, 80, 2);
      measure(5, 0, 1, 60, 0, 1'b0, 0, 2);
      measure(0, 0, 3, 1, 30, 1'b0, 10, 3);
      measure(0, 0, 3, 1, 20, 1'b0, 15, 2);
      measure(2, 0, 100, 7, 20, 1'b1, -500, 2);
      conclude();
   end

   // a hang ends the run as a failure
   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      conclude();
   end
endmodule

bind rsm_speed_meter rsm_checker #(
   .UNIT_10MS_CYC(UNIT_10MS_CYC), .UNIT_100MS_CYC(UNIT_100MS_CYC), .UNIT_1S_CYC(UNIT_1S_CYC)
) u_chk (
   .CLOCK(CLOCK), .NRST(NRST), .CE(CE), .PHASE_A(PHASE_A), .PHASE_B(PHASE_B),
   .SPEED_MODE_SELECTED(SPEED_MODE_SELECTED), .SPEED_MEASURE_COMMAND(SPEED_MEASURE_COMMAND), .CFG(CFG),
   .SPEED_VALUE(SPEED_VALUE), .SPEED_VALID(SPEED_VALID), .SPEED_MEASURING_FLAG(SPEED_MEASURING_FLAG),
   .CHANNEL_STATUS_WORD(CHANNEL_STATUS_WORD)
);

`default_nettype wire
